/* pkg/twc_pkg.sv */
package twc_pkg;
    localparam int CTRL_WIDTH = 16;
    localparam int CLK_PERIOD_NS = 50;
    // reset initialization length, in master_clock cycles
    localparam int INIT_CYCLES_DEFAULT = 1024;
    // latch_strobe least level time: 40 ns plus one master_clock period
    localparam int LATCH_LEVEL_MIN_NS = 40;
    localparam int LATCH_LEVEL_MIN_CYC = (LATCH_LEVEL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    // shift clock least cycle time
    localparam int SHIFT_CYCLE_MIN_NS = 100;
    localparam int SHIFT_CYCLE_MIN_CYC = (SHIFT_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 16'h0000;
    localparam logic HW_MODE_LEVEL = 1'h1;
    localparam logic PIN_RESET = 1'h0;

    typedef struct packed {
        logic mode_sel;
        logic latch;
        logic shift_clk;
        logic data;
    } twc_pins_t;

    localparam twc_pins_t PINS_RESET = '{mode_sel: PIN_RESET, latch: PIN_RESET, shift_clk: PIN_RESET, data: PIN_RESET};

    typedef enum logic [1:0] {
        ST_INIT = 2'h0,
        ST_SW = 2'h1,
        ST_HW = 2'h3
    } twc_state_t;
endpackage

/* core/twc_shift.sv */
`timescale 1ns/100ps
module twc_shift import twc_pkg::*; #(
    parameter int WIDTH = CTRL_WIDTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic shift_en,
    input wire logic bit_in,
    output logic [WIDTH-1:0] word
);
    initial begin
        if (WIDTH < 2) begin
            $error("twc_shift: WIDTH must be at least 2");
        end
    end

    logic [WIDTH-1:0] word_reg;
    wire [WIDTH-1:0] word_next = shift_en ? {word_reg[WIDTH-2:0], bit_in} : word_reg;

    // no reset on purpose: content survives reset and the init period
    always_ff @(posedge clk) begin
        word_reg <= word_next;
    end

    assign word = word_reg;

    // assertion helper: the register powers up unknown, so the keep_last_a and hold_word_a checks wait for a full word
    localparam int FILL_W = $clog2(WIDTH + 1);
    localparam logic [FILL_W-1:0] FILL_FULL = FILL_W'(WIDTH);
    localparam logic [FILL_W-1:0] FILL_ONE = FILL_W'(1);
    localparam logic [FILL_W-1:0] FILL_ZERO = '0;

    logic [FILL_W-1:0] fill_reg;
    wire filled = (fill_reg == FILL_FULL);
    wire [FILL_W-1:0] fill_next = (shift_en && !filled) ? fill_reg + FILL_ONE : fill_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fill_reg <= FILL_ZERO;
        end else begin
            fill_reg <= fill_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    shift_in_bit_a: assert property (shift_en |=> word_reg[0] == $past(bit_in))
        else $error("new bit not at shift register bottom");
    keep_last_a: assert property (filled && shift_en |=> word_reg[WIDTH-1:1] == $past(word_reg[WIDTH-2:0]))
        else $error("older bits did not move up by one");
    hold_word_a: assert property (filled && !shift_en |=> $stable(word_reg))
        else $error("shift register changed without a shift");
endmodule // twc_shift

/* core/twc_port.sv */
`timescale 1ns/100ps
module twc_port import twc_pkg::*; #(
    parameter int WIDTH = CTRL_WIDTH,
    parameter int INIT_CYCLES = INIT_CYCLES_DEFAULT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic shift_clock_in,
    input wire logic serial_data_in,
    input wire logic latch_strobe,
    input wire logic mode_sel,
    output logic [WIDTH-1:0] ctrl_word,
    output logic ctrl_write,
    output logic init_done,
    output logic hw_mode
);
    localparam int CNT_W = $clog2(INIT_CYCLES + 1);
    localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    initial begin
        if (WIDTH != CTRL_WIDTH) begin
            $error("twc_port: WIDTH must match CTRL_WIDTH");
        end
        if (INIT_CYCLES < 2) begin
            $error("twc_port: INIT_CYCLES must be at least 2");
        end
    end

    // pin synchronisers; stage one is read only by stage two
    twc_pins_t pins_raw;
    twc_pins_t sync1_reg;
    twc_pins_t sync2_reg;
    logic shift_clk_prev_reg;
    logic latch_prev_reg;

    assign pins_raw = '{mode_sel: mode_sel, latch: latch_strobe, shift_clk: shift_clock_in, data: serial_data_in};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_reg <= PINS_RESET;
            sync2_reg <= PINS_RESET;
            shift_clk_prev_reg <= PIN_RESET;
            latch_prev_reg <= PIN_RESET;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            shift_clk_prev_reg <= sync2_reg.shift_clk;
            latch_prev_reg <= sync2_reg.latch;
        end
    end

    // data travels the same two stages as the shift clock, so the bit seen with
    // the edge is the one that met setup before it; limited to slow shift clocks
    wire shift_rise = sync2_reg.shift_clk & ~shift_clk_prev_reg;
    wire latch_rise = sync2_reg.latch & ~latch_prev_reg;
    wire hw_sel = (sync2_reg.mode_sel == HW_MODE_LEVEL);

    // state and init counter
    twc_state_t state_reg;
    twc_state_t state_next;
    logic [CNT_W-1:0] init_cnt_reg;
    wire init_end = (init_cnt_reg == INIT_LAST);
    wire [CNT_W-1:0] init_cnt_next = (state_reg == ST_INIT) ? init_cnt_reg + CNT_ONE : CNT_ZERO;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_INIT: begin
                if (init_end) begin
                    state_next = hw_sel ? ST_HW : ST_SW;
                end
            end
            ST_SW: begin
                if (hw_sel) begin
                    state_next = ST_HW;
                end
            end
            ST_HW: begin
                if (!hw_sel) begin
                    state_next = ST_SW;
                end
            end
            default: begin
                state_next = ST_INIT;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_INIT;
            init_cnt_reg <= CNT_ZERO;
        end else begin
            state_reg <= state_next;
            init_cnt_reg <= init_cnt_next;
        end
    end

    // shifting runs during init too, only hardware mode stops it
    wire shift_en = shift_rise && (state_reg != ST_HW);
    wire [WIDTH-1:0] shift_word;

    twc_shift #(
        .WIDTH(WIDTH)
    ) u_shift (
        .clk(clk),
        .reset(reset),
        .shift_en(shift_en),
        .bit_in(sync2_reg.data),
        .word(shift_word)
    );

    // a strobe rise in software mode writes whatever the register holds, stale or not;
    // the host must have clocked the last bit first
    wire write_go = latch_rise && (state_reg == ST_SW);
    wire [WIDTH-1:0] ctrl_word_next = write_go ? shift_word : ctrl_word;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_word <= CTRL_RESET;
            ctrl_write <= 1'h0;
            init_done <= 1'h0;
            hw_mode <= 1'h0;
        end else begin
            ctrl_word <= ctrl_word_next;
            ctrl_write <= write_go;
            init_done <= (state_next != ST_INIT);
            hw_mode <= (state_next == ST_HW);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    latch_load_a: assert property (write_go |=> ctrl_word == $past(shift_word))
        else $error("latched word differs from shift register");
    stale_load_a: assert property (latch_rise && state_reg == ST_SW && !shift_en |=> ctrl_write)
        else $error("strobe without new bits did not write");
    init_block_a: assert property (state_reg == ST_INIT |=> !ctrl_write)
        else $error("control write during init period");
    only_on_write_a: assert property ($changed(ctrl_word) |-> ctrl_write)
        else $error("control register changed without a write");
    init_length_a: assert property (state_reg == ST_INIT && init_end |=> init_done && state_reg != ST_INIT)
        else $error("init period did not end on time");
    init_hold_a: assert property (state_reg == ST_INIT && !init_end |=> !init_done)
        else $error("init ended early");
    hw_ignore_a: assert property (state_reg == ST_HW |-> !shift_en && !write_go)
        else $error("port active in hardware mode");
    mode_follow_a: assert property (init_done && hw_sel |=> hw_mode && state_reg == ST_HW)
        else $error("mode pin not followed");
    strobe_delay_a: assert property ($rose(latch_strobe) && state_reg == ST_SW && !mode_sel |-> ##[3:4] ctrl_write)
        else $error("strobe edge not written in time");

    back_to_back_c: cover property (ctrl_write ##[1:400] ctrl_write);
    stale_write_c: cover property (write_go && !shift_en);
    hw_entry_c: cover property (init_done && !hw_mode ##1 hw_mode);
    init_end_c: cover property (!init_done ##1 init_done);
endmodule // twc_port

/* dv/twc_host.sv */
`timescale 1ns/100ps
module twc_host (
    input wire logic clk,
    output logic shift_clock_in,
    output logic serial_data_in,
    output logic latch_strobe
);
    // idle high on both lines; the synchronisers reset low, so each reset release shifts in one stray bit
    initial begin
        shift_clock_in = 1'h1;
        serial_data_in = 1'h0;
        latch_strobe = 1'h1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask
    // 400 ns link period, data moves on the falling edge
    task automatic shift_bits(input logic [31:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            shift_clock_in = 1'h0;
            serial_data_in = bits[i];
            wait_clk(4);
            shift_clock_in = 1'h1;
            wait_clk(4);
        end
        serial_data_in = ~serial_data_in;
    endtask
    // three cycles cover 40 ns plus one master_clock
    task automatic latch(input bit pulse_low);
        if (pulse_low) begin
            latch_strobe = 1'h0;
            wait_clk(3);
        end
        latch_strobe = 1'h1;
    endtask
    task automatic send(input logic [31:0] bits, input int n, input bit hold_low);
        if (hold_low) begin
            latch_strobe = 1'h0;
            wait_clk(3);
        end
        shift_bits(bits, n);
        wait_clk(2);
        latch(!hold_low);
    endtask
endmodule // twc_host

/* dv/three_wire_control_port_tb_top.sv */
`timescale 1ns/100ps
module three_wire_control_port_tb_top import twc_pkg::*;;
    logic clk, reset, mode_sel;
    wire logic sck, sdi, lat;
    logic [15:0] ctrl_word;
    logic ctrl_write, init_done, hw_mode;
    int mismatches = 0;
    int n_tests = 0;
    int writes = 0;
    int cycles = 0;
    twc_port #(.WIDTH(16), .INIT_CYCLES(300)) u_dut (.clk(clk), .reset(reset), .shift_clock_in(sck),
        .serial_data_in(sdi), .latch_strobe(lat), .mode_sel(mode_sel), .ctrl_word(ctrl_word),
        .ctrl_write(ctrl_write), .init_done(init_done), .hw_mode(hw_mode));
    twc_host u_host (.clk(clk), .shift_clock_in(sck), .serial_data_in(sdi), .latch_strobe(lat));
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // generous ceiling over roughly 1300 cycles of traffic
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (ctrl_write === 1'h1) writes <= writes + 1;
        if (cycles == 4000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // lag counts cycles from strobe rise until the pulse is seen
    task automatic expect_write(input int exp_n, input logic [15:0] exp);
        int w0;
        int lag;
        w0 = writes;
        lag = 0;
        repeat (8) begin
            @(negedge clk);
            if (writes == w0) lag++;
        end
        check("write count", writes - w0, exp_n);
        if (exp_n == 1) begin
            check("write lag", lag <= 4, 1);
            check("ctrl_word", ctrl_word, exp);
        end
    endtask
    task automatic s_init();
        u_host.send(32'hA5C3, 16, 1'h1);
        expect_write(0, 16'h0000);
        check("init_done early", init_done, 1'h0);
        for (int k = 0; k < 400 && init_done !== 1'h1; k++) @(negedge clk);
        check("init_done", init_done, 1'h1);
        u_host.latch(1'h1);
        expect_write(1, 16'hA5C3);
    endtask
    task automatic s_words();
        u_host.send(32'h8001, 16, 1'h0);
        expect_write(1, 16'h8001);
        u_host.send(32'h7FFE, 16, 1'h1);
        expect_write(1, 16'h7FFE);
        u_host.send(32'hF1234, 20, 1'h0);
        expect_write(1, 16'h1234);
    endtask
    task automatic s_hw();
        mode_sel = 1'h1;
        u_host.wait_clk(5);
        check("hw_mode", hw_mode, 1'h1);
        u_host.send(32'h5A5A, 16, 1'h1);
        expect_write(0, 16'h1234);
        check("ctrl_word hold", ctrl_word, 16'h1234);
        mode_sel = 1'h0;
        u_host.wait_clk(5);
        check("sw mode", hw_mode, 1'h0);
        u_host.latch(1'h1);
        expect_write(1, 16'h1234);
    endtask
    // second reset in mid-run, hardware mode chosen at init end
    task automatic s_reset_hw();
        mode_sel = 1'h1;
        reset = 1'h1;
        u_host.wait_clk(20);
        reset = 1'h0;
        check("init_done reset", init_done, 1'h0);
        check("ctrl_word reset", ctrl_word, CTRL_RESET);
        for (int k = 0; k < 400 && init_done !== 1'h1; k++) @(negedge clk);
        check("init_done hw", init_done, 1'h1);
        check("hw after init", hw_mode, 1'h1);
        u_host.latch(1'h1);
        expect_write(0, 16'h0000);
        check("ctrl_word hw hold", ctrl_word, CTRL_RESET);
    endtask
    initial begin
        reset = 1'h1;
        mode_sel = 1'h0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        reset = 1'h0;
        s_init();
        s_words();
        s_hw();
        s_reset_hw();
        end_sim();
    end
endmodule // three_wire_control_port_tb_top
